// ---- hw/tap_pkg.sv ----
`default_nettype none
package tap_pkg;
  // Register byte offsets
  localparam logic [3:0] OFF_STATUS  = 4'h0;
  localparam logic [3:0] OFF_MASK    = 4'h4;
  localparam logic [3:0] OFF_RESP    = 4'h8;
  localparam logic [3:0] OFF_ALERT   = 4'hc;
  // Field positions in the response control word of one sensor
  localparam int RESP_ON_ASSERT   = 0;
  localparam int RESP_ON_DEASSERT = 1;
  localparam int RESP_IRQ         = 2;
  localparam int RESP_SELFREF     = 3;
  localparam int RESP_MEMTHR      = 4;
  localparam int RESP_PERFTHR     = 5;
  localparam int RESP_BITS        = 8;
  // Status bit positions
  localparam int ST_ALARM_RISE = 0;
  localparam int ST_ALARM_FALL = 1;
  localparam int ST_TRIP       = 2;
  localparam int ST_RESP_IRQ   = 3;
  localparam int ST_BITS       = 4;
  localparam logic [31:0] RESP_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- hw/tap_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser, first stage read only by the second
module tap_sync2 #(
  parameter int          W          = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync_out;

  always_comb
  begin
    next_meta     = async_in;
    next_sync_out = meta;
    if (rst)
    begin
      next_meta     = RESET_VAL;
      next_sync_out = RESET_VAL;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    meta     <= next_meta;
    sync_out <= next_sync_out;
  end
endmodule
`default_nettype wire

// ---- hw/tap_thermal_alarm.sv ----
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module tap_thermal_alarm #(
  parameter int N_CORES = 2
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Sensor inputs: cores then memory controller
  input  wire logic [N_CORES-1:0] core_hot,
  input  wire logic               mem_hot,
  input  wire logic [N_CORES-1:0] deep_power_down_state,
  input  wire logic               trip_hot,
  // Open-drain alarm pin
  input  wire logic               alarm_n_in,
  output logic                    alarm_n_out,
  output logic                    alarm_n_oe,
  // Open-drain shutdown pin
  output logic                    overheat_shutdown_n_out,
  output logic                    overheat_shutdown_n_oe,
  output logic                    exec_halt,
  // Per-sensor actions
  output logic [N_CORES:0]        selfref_2x_req,
  output logic [N_CORES:0]        mem_throttle_req,
  output logic [N_CORES:0]        perf_throttle_req,
  output logic                    irq,
  // Avalon-MM slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest
);
  localparam int NS = N_CORES + 1;

  // Pin and sensor inputs come from other domains
  logic [NS+N_CORES+1:0] raw_in;
  logic [NS+N_CORES+1:0] syn_in;
  logic [NS-1:0]         hot_s;
  logic [N_CORES-1:0]    dpd_s;
  logic                  trip_s;
  logic                  pin_low_s;

  assign raw_in = {alarm_n_in, trip_hot, deep_power_down_state,
                   mem_hot, core_hot};

  tap_sync2 #(
    .W         (NS + N_CORES + 2),
    .RESET_VAL ({1'b1, {(NS + N_CORES + 1){1'b0}}})
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (raw_in),
    .sync_out (syn_in)
  );

  assign hot_s     = syn_in[NS-1:0];
  assign dpd_s     = syn_in[NS+N_CORES-1:NS];
  assign trip_s    = syn_in[NS+N_CORES];
  assign pin_low_s = ~syn_in[NS+N_CORES+1];

  // Alarm state
  logic [NS-1:0]      contrib;
  logic               alarm_seen;
  logic               alarm_prev;
  logic               halted;
  logic [NS-1:0]      act_selfref;
  logic [NS-1:0]      act_memthr;
  logic [NS-1:0]      act_perfthr;
  logic [NS-1:0]      next_act_selfref;
  logic [NS-1:0]      next_act_memthr;
  logic [NS-1:0]      next_act_perfthr;
  logic               next_alarm_prev;
  logic               next_halted;
  logic               drive_low;
  logic               next_drive_low;
  logic               rise;
  logic               fall;
  logic [NS-1:0]      resp_irq_ev;

  // Registers
  localparam int ST_BITS_W = tap_pkg::ST_BITS;
  logic [ST_BITS_W-1:0] status;
  logic [ST_BITS_W-1:0] mask;
  logic [31:0]          resp_cfg;
  logic [ST_BITS_W-1:0] next_status;
  logic [ST_BITS_W-1:0] next_mask;
  logic [31:0]          next_resp_cfg;
  logic [31:0]          next_readdata;
  logic                 rd_pending;
  logic                 next_rd_pending;
  logic [ST_BITS_W-1:0] events;

  // Core contribution released in deep power-down
  always_comb
  begin
    contrib = hot_s;
    contrib[N_CORES-1:0] = hot_s[N_CORES-1:0] & ~dpd_s;
  end

  // Own hot sensors or external pull both count as alarm; trip_hot does not
  assign alarm_seen = (|contrib) | pin_low_s;
  assign rise = alarm_seen & ~alarm_prev;
  assign fall = ~alarm_seen & alarm_prev;

  // Each sensor gets its own action word, selected edge fires it
  genvar g;
  generate
    for (g = 0; g < NS; g++)
    begin : g_sensor
      logic [tap_pkg::RESP_BITS-1:0] cfg;
      logic                          fire;
      assign cfg  = resp_cfg[g*tap_pkg::RESP_BITS +: tap_pkg::RESP_BITS];
      assign fire = (rise & cfg[tap_pkg::RESP_ON_ASSERT])
                  | (fall & cfg[tap_pkg::RESP_ON_DEASSERT]);
      assign resp_irq_ev[g] = fire & cfg[tap_pkg::RESP_IRQ];
      always_comb
      begin
        next_act_selfref[g] = act_selfref[g];
        next_act_memthr[g]  = act_memthr[g];
        next_act_perfthr[g] = act_perfthr[g];
        // Actions latch on firing edge, drop on any other alarm edge
        if (fire)
        begin
          next_act_selfref[g] = cfg[tap_pkg::RESP_SELFREF];
          next_act_memthr[g]  = cfg[tap_pkg::RESP_MEMTHR];
          next_act_perfthr[g] = cfg[tap_pkg::RESP_PERFTHR];
        end
        else if (rise | fall)
        begin
          next_act_selfref[g] = 1'b0;
          next_act_memthr[g]  = 1'b0;
          next_act_perfthr[g] = 1'b0;
        end
        if (rst)
        begin
          next_act_selfref[g] = 1'b0;
          next_act_memthr[g]  = 1'b0;
          next_act_perfthr[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_comb
  begin
    // Own sensors only; echoing the pin back would latch the alarm forever
    next_drive_low  = |contrib;
    next_alarm_prev = alarm_seen;
    // Halt is sticky until reset: no recovery from a catastrophic trip
    next_halted     = halted | trip_s;
    if (rst)
    begin
      next_drive_low  = 1'b0;
      next_alarm_prev = 1'b0;
      next_halted     = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    drive_low   <= next_drive_low;
    alarm_prev  <= next_alarm_prev;
    halted      <= next_halted;
    act_selfref <= next_act_selfref;
    act_memthr  <= next_act_memthr;
    act_perfthr <= next_act_perfthr;
  end

  assign alarm_n_out             = 1'b0;
  assign alarm_n_oe              = drive_low;
  assign overheat_shutdown_n_out = 1'b0;
  assign overheat_shutdown_n_oe  = halted;
  assign exec_halt               = halted;
  assign selfref_2x_req          = act_selfref;
  assign mem_throttle_req        = act_memthr;
  assign perf_throttle_req       = act_perfthr;

  // Interrupt status
  always_comb
  begin
    events = '0;
    events[tap_pkg::ST_ALARM_RISE] = rise;
    events[tap_pkg::ST_ALARM_FALL] = fall;
    events[tap_pkg::ST_TRIP]       = trip_s & ~halted;
    events[tap_pkg::ST_RESP_IRQ]   = |resp_irq_ev;
  end

  // Writes answer in one cycle; reads get one wait cycle so readdata is registered
  always_comb
  begin
    next_status     = status;
    next_mask       = mask;
    next_resp_cfg   = resp_cfg;
    next_readdata   = avs_readdata;
    next_rd_pending = 1'b0;
    if (avs_write)
    begin
      case (avs_address)
        tap_pkg::OFF_STATUS:
          next_status = status & ~avs_writedata[ST_BITS_W-1:0];
        tap_pkg::OFF_MASK:   next_mask = avs_writedata[ST_BITS_W-1:0];
        tap_pkg::OFF_RESP:   next_resp_cfg = avs_writedata;
        default:             next_mask = mask;
      endcase
    end
    if (avs_read & ~rd_pending)
    begin
      next_rd_pending = 1'b1;
      case (avs_address)
        tap_pkg::OFF_STATUS: next_readdata = 32'(status);
        tap_pkg::OFF_MASK:   next_readdata = 32'(mask);
        tap_pkg::OFF_RESP:   next_readdata = resp_cfg;
        tap_pkg::OFF_ALERT:
          next_readdata = 32'({halted, pin_low_s, drive_low, contrib});
        default:             next_readdata = tap_pkg::UNMAPPED_READ;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_status = next_status | events;
    if (rst)
    begin
      next_status     = '0;
      next_mask       = tap_pkg::MASK_RESET[ST_BITS_W-1:0];
      next_resp_cfg   = tap_pkg::RESP_RESET;
      next_readdata   = '0;
      next_rd_pending = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    status       <= next_status;
    mask         <= next_mask;
    resp_cfg     <= next_resp_cfg;
    avs_readdata <= next_readdata;
    rd_pending   <= next_rd_pending;
  end

  assign avs_waitrequest = avs_read & ~rd_pending;
  assign irq             = |(status & mask);
endmodule
`default_nettype wire

// ---- tb/tap_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module tap_chk #(
  parameter int N_CORES = 2
) (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic [N_CORES-1:0] core_hot,
  input wire logic               mem_hot,
  input wire logic [N_CORES-1:0] deep_power_down_state,
  input wire logic               trip_hot,
  input wire logic               alarm_n_out,
  input wire logic               alarm_n_oe,
  input wire logic               overheat_shutdown_n_oe,
  input wire logic               exec_halt
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Powered-down cores never count as hot
  logic [N_CORES-1:0] live_hot;
  assign live_hot = core_hot & ~deep_power_down_state;
  // Four samples cover two sync flops plus the output register
  sequence hot_held;
    (mem_hot || (|live_hot))[*4];
  endsequence
  sequence cold_held;
    (!mem_hot && !(|live_hot) && !trip_hot)[*4];
  endsequence
  alarm_on_a: assert property (hot_held |-> alarm_n_oe)
    else $error("alarm not driven");
  alarm_off_a: assert property (cold_held |-> !alarm_n_oe)
    else $error("alarm driven while cold");
  open_drain_a: assert property (alarm_n_out == 1'b0)
    else $error("alarm pin driven high");
  trip_halt_a: assert property (trip_hot[*4] |-> exec_halt)
    else $error("no halt on trip");
  halt_sticky_a: assert property (exec_halt |=> exec_halt)
    else $error("halt dropped");
  halt_pair_a: assert property (exec_halt == overheat_shutdown_n_oe)
    else $error("halt and shutdown differ");
endmodule
bind tap_thermal_alarm tap_chk #(.N_CORES(N_CORES)) tap_chk_i (
  .sys_clk(sys_clk), .rst(rst), .core_hot(core_hot), .mem_hot(mem_hot),
  .deep_power_down_state(deep_power_down_state), .trip_hot(trip_hot),
  .alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe),
  .overheat_shutdown_n_oe(overheat_shutdown_n_oe), .exec_halt(exec_halt)
);
`default_nettype wire

// ---- tb/tap_vr_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tap_vr_model (
  input  wire logic sys_clk,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  input  wire logic pull_req,
  output logic      pin_n
);
  logic pull_q = 1'b0;
  always_ff @(posedge sys_clk)
  begin
    pull_q <= pull_req;
  end
  // Board pull-up wins when nobody sinks the line
  assign pin_n = ~pull_q & (dev_oe ? dev_out : 1'b1);
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module testbench;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  core_hot = '0;
  logic [1:0]  dpd = '0;
  logic        mem_hot = 1'b0;
  logic        trip_hot = 1'b0;
  logic        pull = 1'b0;
  logic        pin_n, a_out, a_oe, sd_out, sd_oe, halt, irq;
  logic [2:0]  selfref, memthr, perfthr;
  logic [3:0]  addr = '0;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic        wreq;
  logic [31:0] wdata = '0;
  logic [31:0] rdata, q;
  int          mismatches = 0;
  int          total_checks = 0;
  tap_thermal_alarm #(.N_CORES(2)) tap_thermal_alarm_i (
    .sys_clk(sys_clk), .rst(rst), .core_hot(core_hot),
    .mem_hot(mem_hot), .deep_power_down_state(dpd),
    .trip_hot(trip_hot), .alarm_n_in(pin_n), .alarm_n_out(a_out),
    .alarm_n_oe(a_oe), .overheat_shutdown_n_out(sd_out),
    .overheat_shutdown_n_oe(sd_oe), .exec_halt(halt),
    .selfref_2x_req(selfref), .mem_throttle_req(memthr),
    .perf_throttle_req(perfthr), .irq(irq), .avs_address(addr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wreq));
  tap_vr_model tap_vr_model_i (.sys_clk(sys_clk), .dev_out(a_out),
    .dev_oe(a_oe), .pull_req(pull), .pin_n(pin_n));
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Idle edge after each access keeps back-to-back requests clean
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    while (wreq !== 1'b0) @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    while (wreq !== 1'b0) @(posedge sys_clk);
    q = rdata;
    rd_en <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic t_reset;
    `CHK({a_oe, a_out, halt, irq}, 4'h0)
    rd(tap_pkg::OFF_MASK);
    `CHK(q, tap_pkg::MASK_RESET)
    rd(4'h2);
    `CHK(q, tap_pkg::UNMAPPED_READ)
  endtask
  task automatic t_mem;
    wr(tap_pkg::OFF_RESP, 32'h003d_0000);
    wr(tap_pkg::OFF_MASK, 32'h0000_0008);
    mem_hot <= 1'b1;
    cyc(4);
    `CHK(a_oe, 1'b1)
    `CHK({selfref[2], memthr[2], perfthr[2], irq}, 4'hf)
    rd(tap_pkg::OFF_STATUS);
    `CHK(q, 32'h0000_0009)
    wr(tap_pkg::OFF_STATUS, 32'h0000_0009);
    `CHK(irq, 1'b0)
    mem_hot <= 1'b0;
    // Own pull echoes back through the pin, so the fall lags three edges
    cyc(7);
    `CHK({a_oe, selfref[2]}, 2'b00)
  endtask
  task automatic t_pull;
    wr(tap_pkg::OFF_STATUS, 32'h0000_000f);
    wr(tap_pkg::OFF_RESP, 32'h0022_2222);
    rd(tap_pkg::OFF_RESP);
    `CHK(q, 32'h0022_2222)
    pull <= 1'b1;
    cyc(5);
    `CHK({a_oe, perfthr}, 4'h0)
    pull <= 1'b0;
    cyc(5);
    `CHK(perfthr, 3'b111)
    rd(tap_pkg::OFF_STATUS);
    `CHK(q, 32'h0000_0003)
  endtask
  task automatic t_dpd;
    dpd <= 2'b10;
    core_hot <= 2'b10;
    cyc(5);
    `CHK(a_oe, 1'b0)
    rd(tap_pkg::OFF_ALERT);
    `CHK(q, 32'h0000_0000)
    dpd <= 2'b00;
    cyc(4);
    `CHK({a_oe, perfthr}, 4'h8)
    core_hot <= 2'b00;
    cyc(4);
  endtask
  task automatic t_trip;
    trip_hot <= 1'b1;
    cyc(4);
    trip_hot <= 1'b0;
    cyc(4);
    `CHK({halt, sd_oe, sd_out}, 3'b110)
    rd(tap_pkg::OFF_STATUS);
    `CHK(q[tap_pkg::ST_TRIP], 1'b1)
    rd(tap_pkg::OFF_ALERT);
    `CHK(q, 32'h0000_0020)
  endtask
  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    cyc(5);
    rst <= 1'b0;
    t_reset;
    t_mem;
    t_pull;
    t_dpd;
    t_trip;
    finish_test;
  end
  initial
  begin
    cyc(2000);
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
